/* common/clsc_regs.vh */
// Purpose: constants for the core loop and status control block
// Assumes: status word and core control word are 16 bits
// Notes:   field positions are bit indexes within their word
`ifndef CLSC_REGS_VH
`define CLSC_REGS_VH

// Register select codes on the core's special-register port
`define CLSC_SEL_TABLE_PAGE   3'h0
`define CLSC_SEL_PROG_WINDOW  3'h1
`define CLSC_SEL_REPEAT_CNT   3'h2
`define CLSC_SEL_LOOP_CNT     3'h3
`define CLSC_SEL_LOOP_FIRST   3'h4
`define CLSC_SEL_LOOP_LAST    3'h5
`define CLSC_SEL_STATUS       3'h6
`define CLSC_SEL_CORE_CTRL    3'h7

// Status word fields
`define CLSC_SR_C             0
`define CLSC_SR_Z             1
`define CLSC_SR_OV            2
`define CLSC_SR_N             3
`define CLSC_SR_RA            4
`define CLSC_SR_PRIO_LO       5
`define CLSC_SR_PRIO_HI       7
`define CLSC_SR_HC            8
`define CLSC_SR_DA            9
`define CLSC_SR_SAB           10
`define CLSC_SR_OAB           11
`define CLSC_SR_SB            12
`define CLSC_SR_SA            13
`define CLSC_SR_OB            14
`define CLSC_SR_OA            15

// Core control fields kept here
`define CLSC_CC_TRAP          3
`define CLSC_CC_EXIT          11

// Reset values and widths
`define CLSC_RST_BYTE         8'h00
`define CLSC_RST_CNT          14'h0000
`define CLSC_RST_ADDR         23'h000000
`define CLSC_CNT_W            14
`define CLSC_ADDR_W           23
`define CLSC_INSTR_STEP       23'h000002

`endif

/* hdl/clsc_loop_ctx.v */
// Purpose: hardware loop context with a one-deep shadow
// Assumes: one loop start per cycle at most, pulses from the sequencer
// Notes:   a third nested start overwrites the shadow; software stacks deeper
`include "clsc_regs.vh"

module clsc_loop_ctx (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire [13:0] start_count,
  input  wire [22:0] start_first,
  input  wire [22:0] start_last,
  input  wire        wrap,
  input  wire        finish,
  input  wire        wr_cnt,
  input  wire        wr_first,
  input  wire        wr_last,
  input  wire [22:0] wr_data,
  output reg  [13:0] count,
  output reg  [22:0] first_addr,
  output reg  [22:0] last_addr,
  output reg         active,
  output reg         shadow_valid
);

  reg [13:0] sh_count;
  reg [22:0] sh_first;
  reg [22:0] sh_last;
  reg        sh_active;

  always @(posedge clk) begin
    if (rst) begin
      count        <= `CLSC_RST_CNT;
      first_addr   <= `CLSC_RST_ADDR;
      last_addr    <= `CLSC_RST_ADDR;
      active       <= 1'b0;
      sh_count     <= `CLSC_RST_CNT;
      sh_first     <= `CLSC_RST_ADDR;
      sh_last      <= `CLSC_RST_ADDR;
      sh_active    <= 1'b0;
      shadow_valid <= 1'b0;
    end else if (start) begin
      sh_count     <= count;
      sh_first     <= first_addr;
      sh_last      <= last_addr;
      sh_active    <= active;
      shadow_valid <= active;
      count        <= start_count;
      first_addr   <= start_first;
      last_addr    <= start_last;
      active       <= 1'b1;
    end else if (finish) begin
      // Inner loop done: the outer one picks up where it stood
      count        <= sh_count;
      first_addr   <= sh_first;
      last_addr    <= sh_last;
      active       <= sh_active;
      shadow_valid <= 1'b0;
      sh_active    <= 1'b0;
    end else begin
      if (wrap)
        count <= count - 14'h0001;
      else if (wr_cnt)
        count <= wr_data[13:0];
      if (wr_first)
        first_addr <= wr_data;
      if (wr_last)
        last_addr <= wr_data;
    end
  end

endmodule

/* hdl/clsc_core_ctrl.v */
// Purpose: page, repeat, hardware loop, status flag and priority control
// Assumes: one instruction completes per cycle, flagged by the sequencer
// Notes:   registers reached over the core special-register select port
`include "clsc_regs.vh"

// How it works
// - Table page feeds upper table address bits.
// - Window page maps program into upper data.
// - Repeat loads count, runs target count+1.
// - Cleared repeat count ends suspended repeat.
// - Loop count loads from literal or register.
// - Loop start is the following instruction.
// - At last address, fetch start, no stall.
// - New loop shadows the active loop context.
// - ALU sets C Z OV N half-carry; borrow inverted.
// - Zero flag plain except carry-input ops.
// - Shadow save and restore MCU flags.
// - Exception stacks status low byte, restores.
// - Loop active set at start, clears at end.
// - Repeat active tracks the repeated instruction.
// - Active flags read-only; exit bit ends loop.
// - Stacked repeat flag cleared stops repeat.
// - Guard overflow flags from guard bit spill.
// - Sticky top overflow flags until software clears.
// - Combined flags OR; combined clear clears both.
// - Priority is trap bit above three status bits.
// - Trap bit hardware set, software clear only.
// - Accept exception only above current priority.
// - Servicing sets priority; low bits stay writable.
// - Shadows are one entry deep.
// - Exit bit ends loop at iteration end, reads zero.
module clsc_core_ctrl (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire [2:0]  REG_SEL,
  input  wire        REG_WR,
  input  wire [1:0]  REG_BE,
  input  wire [22:0] REG_WDATA,
  output reg  [22:0] REG_RDATA,
  input  wire        TABLE_ACCESS,
  input  wire [15:0] TABLE_OFFSET,
  output reg  [23:0] TABLE_ADDR,
  input  wire [15:0] DATA_ADDR,
  output reg         WINDOW_HIT,
  output reg  [23:0] WINDOW_ADDR,
  input  wire        INSTR_DONE,
  input  wire [22:0] INSTR_PC,
  input  wire        REPEAT_START,
  input  wire        REPEAT_USE_WREG,
  input  wire [13:0] FOURTEEN_BIT_LITERAL,
  input  wire [13:0] REPEAT_COUNT_WREG,
  input  wire        LOOP_START,
  input  wire        LOOP_USE_WREG,
  input  wire [15:0] LOOP_COUNT_WREG,
  input  wire [22:0] LOOP_END_EXPR,
  output reg         FETCH_REDIRECT,
  output reg  [22:0] FETCH_ADDR,
  output reg         REPEAT_HOLD,
  input  wire        ALU_UPDATE,
  input  wire        ALU_SUB,
  input  wire        ALU_CARRY_IN_OP,
  input  wire        ALU_CARRY,
  input  wire        ALU_ZERO,
  input  wire        ALU_OV,
  input  wire        ALU_NEG,
  input  wire        ALU_HALF_CARRY,
  input  wire        SHADOW_SAVE_OP,
  input  wire        SHADOW_RESTORE_OP,
  input  wire        ACC_A_GUARD_EVT,
  input  wire        ACC_B_GUARD_EVT,
  input  wire        ACC_A_TOP_EVT,
  input  wire        ACC_B_TOP_EVT,
  input  wire        ACC_FLAGS_UPDATE,
  input  wire        EXC_PENDING,
  input  wire [3:0]  EXC_LEVEL,
  input  wire        EXC_IS_TRAP,
  input  wire        EXC_ENTER,
  output reg         EXC_ACCEPT,
  output reg  [7:0]  STACKED_STATUS,
  input  wire        EXC_RETURN,
  input  wire        TRAP_SERVICED,
  input  wire [7:0]  RESTORE_STATUS,
  output reg  [3:0]  CPU_PRIORITY_LEVEL,
  output reg         LOOP_BODY_ACTIVE,
  output reg         SINGLE_INSTR_LOOP_ACTIVE
);

  reg  [7:0]  table_page;
  reg  [7:0]  prog_window_page;
  reg  [13:0] repeat_counter;
  reg         flag_c;
  reg         flag_z;
  reg         flag_ov;
  reg         flag_n;
  reg         flag_hc;
  reg         ra;
  reg  [2:0]  prio;
  reg         trap_priority_bit;
  reg         early_loop_exit;
  reg         acc_a_guard_overflow;
  reg         acc_b_guard_spill;
  reg         acc_a_top_sticky;
  reg         acc_b_top_sticky;
  reg  [4:0]  mcu_shadow;
  reg  [15:0] status_word;
  reg  [15:0] core_ctrl_word;
  reg  [22:0] next_rdata;
  reg  [3:0]  next_level;

  wire [13:0] loop_iter_counter;
  wire [22:0] loop_first_addr;
  wire [22:0] loop_last_addr;
  wire        loop_active;
  wire        loop_shadow_valid;

  wire        wr_lo = REG_WR & REG_BE[0];
  wire        wr_hi = REG_WR & REG_BE[1];
  wire        sel_sr = (REG_SEL == `CLSC_SEL_STATUS);
  wire        sel_cc = (REG_SEL == `CLSC_SEL_CORE_CTRL);
  wire        at_last = loop_active & INSTR_DONE
                        & (INSTR_PC == loop_last_addr);
  wire        loop_final = at_last
                           & ((loop_iter_counter == `CLSC_RST_CNT)
                              | early_loop_exit);
  wire        loop_wrap = at_last & ~loop_final;
  wire [13:0] next_loop_count = LOOP_USE_WREG
                                ? LOOP_COUNT_WREG[13:0]
                                : FOURTEEN_BIT_LITERAL;

  // Byte-lane merge for a 16-bit register write
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] din;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? din[15:8] : old[15:8],
                 be[0] ? din[7:0]  : old[7:0]};
    end
  endfunction

  clsc_loop_ctx u_loop (
    .clk          (REF_CLK),
    .rst          (RST),
    .start        (LOOP_START),
    .start_count  (next_loop_count),
    .start_first  (INSTR_PC + `CLSC_INSTR_STEP),
    .start_last   (LOOP_END_EXPR),
    .wrap         (loop_wrap),
    .finish       (loop_final),
    .wr_cnt       (REG_WR && REG_SEL == `CLSC_SEL_LOOP_CNT),
    .wr_first     (REG_WR && REG_SEL == `CLSC_SEL_LOOP_FIRST),
    .wr_last      (REG_WR && REG_SEL == `CLSC_SEL_LOOP_LAST),
    .wr_data      (REG_WDATA),
    .count        (loop_iter_counter),
    .first_addr   (loop_first_addr),
    .last_addr    (loop_last_addr),
    .active       (loop_active),
    .shadow_valid (loop_shadow_valid)
  );

  always @* begin
    status_word = {acc_a_guard_overflow, acc_b_guard_spill,
                   acc_a_top_sticky, acc_b_top_sticky,
                   acc_a_guard_overflow | acc_b_guard_spill,
                   acc_a_top_sticky | acc_b_top_sticky,
                   loop_active, flag_hc, prio, ra,
                   flag_n, flag_ov, flag_z, flag_c};
    // Exit bit always reads zero; other mode bits live elsewhere
    core_ctrl_word = 16'h0000;
    core_ctrl_word[`CLSC_CC_TRAP] = trap_priority_bit;
    core_ctrl_word[`CLSC_CC_EXIT] = 1'b0;
    case (REG_SEL)
      `CLSC_SEL_TABLE_PAGE:  next_rdata = {15'h0000, table_page};
      `CLSC_SEL_PROG_WINDOW: next_rdata = {15'h0000, prog_window_page};
      `CLSC_SEL_REPEAT_CNT:  next_rdata = {9'h000, repeat_counter};
      `CLSC_SEL_LOOP_CNT:    next_rdata = {9'h000, loop_iter_counter};
      `CLSC_SEL_LOOP_FIRST:  next_rdata = loop_first_addr;
      `CLSC_SEL_LOOP_LAST:   next_rdata = loop_last_addr;
      `CLSC_SEL_STATUS:      next_rdata = {7'h00, status_word};
      `CLSC_SEL_CORE_CTRL:   next_rdata = {7'h00, core_ctrl_word};
      default:               next_rdata = 23'h000000;
    endcase
    next_level = {trap_priority_bit, prio};
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      table_page           <= `CLSC_RST_BYTE;
      prog_window_page     <= `CLSC_RST_BYTE;
      repeat_counter       <= `CLSC_RST_CNT;
      {flag_hc, flag_n, flag_ov, flag_z, flag_c} <= 5'h00;
      mcu_shadow           <= 5'h00;
      ra                   <= 1'b0;
      prio                 <= 3'h0;
      trap_priority_bit    <= 1'b0;
      early_loop_exit      <= 1'b0;
      acc_a_guard_overflow <= 1'b0;
      acc_b_guard_spill    <= 1'b0;
      acc_a_top_sticky     <= 1'b0;
      acc_b_top_sticky     <= 1'b0;
      REG_RDATA            <= 23'h000000;
      TABLE_ADDR           <= 24'h000000;
      WINDOW_HIT           <= 1'b0;
      WINDOW_ADDR          <= 24'h000000;
      FETCH_REDIRECT       <= 1'b0;
      FETCH_ADDR           <= `CLSC_RST_ADDR;
      REPEAT_HOLD          <= 1'b0;
      EXC_ACCEPT           <= 1'b0;
      STACKED_STATUS       <= 8'h00;
      CPU_PRIORITY_LEVEL   <= 4'h0;
      LOOP_BODY_ACTIVE     <= 1'b0;
      SINGLE_INSTR_LOOP_ACTIVE <= 1'b0;
    end else begin
      REG_RDATA <= next_rdata;
      if (REG_WR && REG_SEL == `CLSC_SEL_TABLE_PAGE && REG_BE[0])
        table_page <= REG_WDATA[7:0];
      if (REG_WR && REG_SEL == `CLSC_SEL_PROG_WINDOW && REG_BE[0])
        prog_window_page <= REG_WDATA[7:0];
      // Address moves only on a table transfer, so it holds between them
      if (TABLE_ACCESS)
        TABLE_ADDR <= {table_page, TABLE_OFFSET};
      // Upper half of data space shows 32 Kbytes of program space
      WINDOW_HIT  <= DATA_ADDR[15];
      WINDOW_ADDR <= {1'b0, prog_window_page, DATA_ADDR[14:0]};

      // Repeat sequencing; the hold ends when an instruction completes with the count at zero
      if (REPEAT_START) begin
        repeat_counter <= REPEAT_USE_WREG ? REPEAT_COUNT_WREG
                                          : FOURTEEN_BIT_LITERAL;
        ra <= 1'b1;
      end else if (ra && INSTR_DONE) begin
        if (repeat_counter == `CLSC_RST_CNT)
          ra <= 1'b0;
        else
          repeat_counter <= repeat_counter - 14'h0001;
      end else if (REG_WR && REG_SEL == `CLSC_SEL_REPEAT_CNT) begin
        // A handler clearing the count ends the repeat on return
        repeat_counter <= REG_WDATA[13:0];
      end
      REPEAT_HOLD <= ra && !(INSTR_DONE && repeat_counter == `CLSC_RST_CNT);

      // Zero-overhead wrap: fetch redirects in the cycle after the last instruction completes
      FETCH_REDIRECT <= loop_wrap;
      FETCH_ADDR     <= loop_first_addr;

      // Early exit is consumed when the current iteration ends
      if (sel_cc && wr_hi && REG_WDATA[`CLSC_CC_EXIT])
        early_loop_exit <= 1'b1;
      else if (loop_final || !loop_active)
        early_loop_exit <= 1'b0;

      // MCU flags: ALU, shadow, exception return, software writes
      if (SHADOW_SAVE_OP)
        mcu_shadow <= {flag_hc, flag_n, flag_ov, flag_z, flag_c};
      if (SHADOW_RESTORE_OP) begin
        {flag_hc, flag_n, flag_ov, flag_z, flag_c} <= mcu_shadow;
      end else if (ALU_UPDATE) begin
        flag_c  <= ALU_SUB ? ~ALU_CARRY : ALU_CARRY;
        flag_ov <= ALU_OV;
        flag_n  <= ALU_NEG;
        flag_hc <= ALU_HALF_CARRY;
        if (!ALU_CARRY_IN_OP)
          flag_z <= ALU_ZERO;
        else if (!ALU_ZERO)
          flag_z <= 1'b0;
      end else if (EXC_RETURN) begin
        {prio, ra, flag_n, flag_ov, flag_z, flag_c} <= RESTORE_STATUS;
        if (!RESTORE_STATUS[`CLSC_SR_RA])
          repeat_counter <= `CLSC_RST_CNT;
      end else if (sel_sr && wr_lo) begin
        // Repeat-active bit ignores software; it is read-only
        {prio, flag_n, flag_ov, flag_z, flag_c} <=
          {REG_WDATA[7:5], REG_WDATA[3:0]};
      end
      if (sel_sr && wr_hi && !ALU_UPDATE && !SHADOW_RESTORE_OP)
        flag_hc <= REG_WDATA[`CLSC_SR_HC];

      // Accumulator status; set wins over a same-cycle software clear
      if (ACC_FLAGS_UPDATE) begin
        acc_a_guard_overflow <= ACC_A_GUARD_EVT;
        acc_b_guard_spill    <= ACC_B_GUARD_EVT;
      end
      if (ACC_A_TOP_EVT)
        acc_a_top_sticky <= 1'b1;
      else if (sel_sr && wr_hi && (!REG_WDATA[`CLSC_SR_SA]
                                   || !REG_WDATA[`CLSC_SR_SAB]))
        acc_a_top_sticky <= 1'b0;
      if (ACC_B_TOP_EVT)
        acc_b_top_sticky <= 1'b1;
      else if (sel_sr && wr_hi && (!REG_WDATA[`CLSC_SR_SB]
                                   || !REG_WDATA[`CLSC_SR_SAB]))
        acc_b_top_sticky <= 1'b0;

      // Exception priority handling
      EXC_ACCEPT <= EXC_PENDING && (EXC_LEVEL > next_level);
      if (EXC_ENTER) begin
        STACKED_STATUS <= status_word[7:0];
        prio <= EXC_LEVEL[2:0];
        if (EXC_IS_TRAP)
          trap_priority_bit <= 1'b1;
      end else if (TRAP_SERVICED ||
                   (sel_cc && wr_lo && !REG_WDATA[`CLSC_CC_TRAP])) begin
        trap_priority_bit <= 1'b0;
      end
      CPU_PRIORITY_LEVEL <= next_level;
      LOOP_BODY_ACTIVE   <= loop_active;
      SINGLE_INSTR_LOOP_ACTIVE <= ra;
    end
  end

endmodule

/* testbench/clsc_core_ctrl_checker.sv */
// Purpose: port-level assertions for the core loop and status control block
// Assumes: single clock domain, synchronous active-high reset
// Notes:   read data lags the select by one cycle
`include "clsc_regs.vh"

module clsc_core_ctrl_checker (
  input wire        REF_CLK,
  input wire        RST,
  input wire [2:0]  REG_SEL,
  input wire [22:0] REG_RDATA,
  input wire        TABLE_ACCESS,
  input wire [15:0] TABLE_OFFSET,
  input wire [23:0] TABLE_ADDR,
  input wire [15:0] DATA_ADDR,
  input wire        WINDOW_HIT,
  input wire [23:0] WINDOW_ADDR,
  input wire        INSTR_DONE,
  input wire        REPEAT_START,
  input wire        LOOP_START,
  input wire        FETCH_REDIRECT,
  input wire        EXC_PENDING,
  input wire [3:0]  EXC_LEVEL,
  input wire        EXC_ENTER,
  input wire        EXC_ACCEPT,
  input wire [3:0]  CPU_PRIORITY_LEVEL,
  input wire        LOOP_BODY_ACTIVE,
  input wire        SINGLE_INSTR_LOOP_ACTIVE
);
  logic [2:0] enter_lvl;

  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // Remembers the level taken so the priority can be compared later
  always @(posedge REF_CLK) begin
    if (EXC_ENTER) begin
      enter_lvl <= EXC_LEVEL[2:0];
    end
  end

  sequence rep_go;
    REPEAT_START ##1 1'b1;
  endsequence
  sequence loop_go;
    LOOP_START ##1 1'b1;
  endsequence

  table_addr_a: assert property (
    !$past(RST) && $past(TABLE_ACCESS) |->
    TABLE_ADDR[15:0] == $past(TABLE_OFFSET)) else $error("table offset lost");
  table_hold_a: assert property (
    !$past(RST) && !$past(TABLE_ACCESS) |-> $stable(TABLE_ADDR))
    else $error("table address moved without a transfer");
  window_map_a: assert property (!$past(RST) |->
    WINDOW_HIT == $past(DATA_ADDR[15]) &&
    WINDOW_ADDR[14:0] == $past(DATA_ADDR[14:0])) else $error("window map bad");
  accept_gate_a: assert property (!$past(EXC_PENDING) ||
    $past(EXC_LEVEL) == 4'h0 |-> !EXC_ACCEPT) else $error("accept ungated");
  accept_level_a: assert property (
    !$past(RST) |-> EXC_ACCEPT ==
    ($past(EXC_PENDING) && ($past(EXC_LEVEL) > CPU_PRIORITY_LEVEL)))
    else $error("accept not gated by level");
  repeat_flag_a: assert property (rep_go |=> SINGLE_INSTR_LOOP_ACTIVE)
    else $error("repeat flag not raised");
  loop_flag_a: assert property (loop_go |=> LOOP_BODY_ACTIVE)
    else $error("loop flag not raised");
  redirect_cause_a: assert property (FETCH_REDIRECT |->
    $past(INSTR_DONE)) else $error("redirect without completion");
  prio_enter_a: assert property (EXC_ENTER |-> ##[1:2]
    CPU_PRIORITY_LEVEL[2:0] == enter_lvl) else $error("priority not taken");
  combined_flags_a: assert property (
    $past(REG_SEL) == `CLSC_SEL_STATUS |->
    REG_RDATA[11] == (REG_RDATA[15] | REG_RDATA[14]) &&
    REG_RDATA[10] == (REG_RDATA[13] | REG_RDATA[12])) else $error("or flags");
endmodule

bind clsc_core_ctrl clsc_core_ctrl_checker u_clsc_core_ctrl_checker (.*);

/* testbench/clsc_core_ctrl_bench.sv */
// Purpose: self-checking bench for the core loop and status control block
// Assumes: inputs change on the falling edge; reads lag the select
// Notes:   ALU flag cases come from a table, the rest are hand tests
`include "clsc_regs.vh"

module clsc_core_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] ST = `CLSC_SEL_STATUS;
  localparam logic [2:0] CC = `CLSC_SEL_CORE_CTRL;
  logic        REF_CLK = 1'b0, RST = 1'b1, REG_WR = 0, TABLE_ACCESS = 0;
  logic        INSTR_DONE = 0, REPEAT_START = 0, REPEAT_USE_WREG = 0;
  logic        LOOP_START = 0, LOOP_USE_WREG = 0, ALU_UPDATE = 0, ALU_SUB = 0;
  logic        ALU_CARRY_IN_OP = 0, ALU_CARRY = 0, ALU_ZERO = 0, ALU_OV = 0;
  logic        ALU_NEG = 0, ALU_HALF_CARRY = 0, SHADOW_SAVE_OP = 0;
  logic        SHADOW_RESTORE_OP = 0, ACC_A_GUARD_EVT = 0, ACC_B_GUARD_EVT = 0;
  logic        ACC_A_TOP_EVT = 0, ACC_B_TOP_EVT = 0, ACC_FLAGS_UPDATE = 0;
  logic        EXC_PENDING = 0, EXC_IS_TRAP = 0, EXC_ENTER = 0, EXC_RETURN = 0;
  logic        TRAP_SERVICED = 0;
  logic [2:0]  REG_SEL = 0;
  logic [1:0]  REG_BE = 0;
  logic [3:0]  EXC_LEVEL = 0;
  logic [7:0]  RESTORE_STATUS = 0;
  logic [13:0] FOURTEEN_BIT_LITERAL = 0, REPEAT_COUNT_WREG = 0;
  logic [15:0] TABLE_OFFSET = 0, DATA_ADDR = 0, LOOP_COUNT_WREG = 0;
  logic [22:0] REG_WDATA = 0, INSTR_PC = 0, LOOP_END_EXPR = 0;
  logic [22:0] REG_RDATA, FETCH_ADDR;
  logic [23:0] TABLE_ADDR, WINDOW_ADDR;
  logic        WINDOW_HIT, FETCH_REDIRECT, REPEAT_HOLD, EXC_ACCEPT;
  logic        LOOP_BODY_ACTIVE, SINGLE_INSTR_LOOP_ACTIVE;
  logic [7:0]  STACKED_STATUS;
  logic [3:0]  CPU_PRIORITY_LEVEL;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // Flag inputs {sub, carry-in op, carry, zero, ov, neg, half} and low status
  logic [15:0] rows [7] = '{{7'b0011001, 9'h103}, {7'b1010010, 9'h008},
    {7'b1000100, 9'h005}, {7'b0111000, 9'h001}, {7'b0001000, 9'h002},
    {7'b1111000, 9'h002}, {7'b0100000, 9'h000}};

  clsc_core_ctrl u_clsc_core_ctrl (.*);

  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  task test_done();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end

  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task wr(input logic [2:0] s, input logic [1:0] be, input logic [22:0] d);
    REG_SEL = s;
    REG_BE = be;
    REG_WDATA = d;
    pulse(REG_WR);
  endtask
  task rdchk(input logic [2:0] s, input logic [22:0] m, input logic [22:0] e);
    REG_SEL = s;
    tick(2);
    check({1'b0, REG_RDATA & m}, {1'b0, e});
  endtask
  task alu(input logic [6:0] f);
    {ALU_SUB, ALU_CARRY_IN_OP, ALU_CARRY, ALU_ZERO} = f[6:3];
    {ALU_OV, ALU_NEG, ALU_HALF_CARRY} = f[2:0];
    pulse(ALU_UPDATE);
  endtask
  task done(input logic [22:0] pc);
    INSTR_PC = pc;
    pulse(INSTR_DONE);
  endtask
  task loop(input logic [22:0] pc, input logic w, input logic [22:0] last);
    INSTR_PC = pc;
    LOOP_USE_WREG = w;
    LOOP_END_EXPR = last;
    pulse(LOOP_START);
  endtask

  initial begin
    tick(2);
    RST = 1'b0;
    for (int s = 0; s < 8; s++) rdchk(3'(s), '1, 23'h0);
    wr(`CLSC_SEL_TABLE_PAGE, 2'b11, 23'h5A);
    tick(1);
    wr(`CLSC_SEL_PROG_WINDOW, 2'b11, 23'h03);
    check(TABLE_ADDR, 24'h000000);
    TABLE_ACCESS = 1'b1;
    TABLE_OFFSET = 16'h1234;
    DATA_ADDR = 16'h8456;
    tick(2);
    check(TABLE_ADDR, 24'h5A1234);
    check(WINDOW_ADDR, 24'h018456);
    foreach (rows[i]) begin
      alu(rows[i][15:9]);
      rdchk(ST, 23'h1FF, {14'h0, rows[i][8:0]});
    end
    alu(7'b0011001);
    pulse(SHADOW_SAVE_OP);
    alu(7'b0000000);
    pulse(SHADOW_RESTORE_OP);
    rdchk(ST, 23'h1FF, 23'h103);
    FOURTEEN_BIT_LITERAL = 14'h2;
    REPEAT_COUNT_WREG = 14'h1;
    for (int k = 0; k < 2; k++) begin
      REPEAT_USE_WREG = k[0];
      pulse(REPEAT_START);
      rdchk(`CLSC_SEL_REPEAT_CNT, '1, 23'(2 - k));
      repeat (2 - k) begin
        done(23'h200);
        tick(1);
      end
      rdchk(ST, 23'h10, 23'h10);
      check({23'h0, REPEAT_HOLD}, 24'h1);
      done(23'h200);
      rdchk(ST, 23'h10, 23'h0);
      check({23'h0, REPEAT_HOLD}, 24'h0);
    end
    REPEAT_USE_WREG = 1'b0;
    FOURTEEN_BIT_LITERAL = 14'h5;
    pulse(REPEAT_START);
    done(23'h200);
    pulse(EXC_RETURN);
    rdchk(ST, 23'h10, 23'h0);
    rdchk(`CLSC_SEL_REPEAT_CNT, '1, 23'h0);
    // Count cleared mid-repeat ends it at the next completion
    pulse(REPEAT_START);
    wr(`CLSC_SEL_REPEAT_CNT, 2'b11, 23'h0);
    done(23'h200);
    rdchk(ST, 23'h10, 23'h0);
    wr(ST, 2'b11, 23'h0210);
    rdchk(ST, 23'h210, 23'h0);
    FOURTEEN_BIT_LITERAL = 14'h3;
    LOOP_COUNT_WREG = 16'hC001;
    loop(23'h100, 1'b0, 23'h120);
    tick(1);
    loop(23'h104, 1'b1, 23'h10C);
    rdchk(`CLSC_SEL_LOOP_CNT, '1, 23'h1);
    rdchk(`CLSC_SEL_LOOP_FIRST, '1, 23'h106);
    rdchk(`CLSC_SEL_LOOP_LAST, '1, 23'h10C);
    done(23'h10C);
    check({23'h0, FETCH_REDIRECT}, 24'h1);
    check({1'b0, FETCH_ADDR}, 24'h106);
    tick(1);
    done(23'h10C);
    check({23'h0, FETCH_REDIRECT}, 24'h0);
    rdchk(`CLSC_SEL_LOOP_FIRST, '1, 23'h102);
    rdchk(`CLSC_SEL_LOOP_CNT, '1, 23'h3);
    rdchk(ST, 23'h200, 23'h200);
    wr(CC, 2'b11, 23'h800);
    rdchk(CC, 23'h800, 23'h0);
    done(23'h120);
    check({23'h0, FETCH_REDIRECT}, 24'h0);
    rdchk(ST, 23'h200, 23'h0);
    wr(`CLSC_SEL_LOOP_LAST, 2'b11, 23'h130);
    rdchk(`CLSC_SEL_LOOP_LAST, '1, 23'h130);
    wr(ST, 2'b01, 23'hA0);
    EXC_PENDING = 1'b1;
    EXC_LEVEL = 4'h5;
    tick(2);
    check({23'h0, EXC_ACCEPT}, 24'h0);
    EXC_LEVEL = 4'h6;
    tick(2);
    check({23'h0, EXC_ACCEPT}, 24'h1);
    pulse(EXC_ENTER);
    check({16'h0, STACKED_STATUS}, 24'hA0);
    tick(2);
    check({20'h0, CPU_PRIORITY_LEVEL}, 24'h6);
    EXC_IS_TRAP = 1'b1;
    EXC_LEVEL = 4'hB;
    pulse(EXC_ENTER);
    tick(2);
    check({20'h0, CPU_PRIORITY_LEVEL}, 24'hB);
    rdchk(CC, 23'h8, 23'h8);
    pulse(TRAP_SERVICED);
    wr(CC, 2'b01, 23'h8);
    rdchk(CC, 23'h8, 23'h0);
    EXC_PENDING = 1'b0;
    EXC_IS_TRAP = 1'b0;
    RESTORE_STATUS = 8'hA0;
    pulse(EXC_RETURN);
    tick(2);
    check({20'h0, CPU_PRIORITY_LEVEL}, 24'h5);
    ACC_A_GUARD_EVT = 1'b1;
    pulse(ACC_FLAGS_UPDATE);
    pulse(ACC_B_TOP_EVT);
    rdchk(ST, 23'hFC00, 23'h9C00);
    ACC_A_GUARD_EVT = 1'b0;
    ACC_B_GUARD_EVT = 1'b1;
    pulse(ACC_FLAGS_UPDATE);
    rdchk(ST, 23'hFC00, 23'h5C00);
    ACC_B_GUARD_EVT = 1'b0;
    pulse(ACC_FLAGS_UPDATE);
    pulse(ACC_A_TOP_EVT);
    rdchk(ST, 23'hFC00, 23'h3400);
    // Writing SA as one with the combined bit at zero must still clear both sticky bits
    wr(ST, 2'b10, 23'h2000);
    rdchk(ST, 23'hFC00, 23'h0);
    // Mid-run reset must bring priority and table page back to zero
    RST = 1'b1;
    tick(2);
    RST = 1'b0;
    check({20'h0, CPU_PRIORITY_LEVEL}, 24'h0);
    rdchk(`CLSC_SEL_TABLE_PAGE, '1, 23'h0);
    test_done();
  end
endmodule
